// File: rtl/fault_diag_pkg.sv
// Purpose: Shared constants for the fault diagnostic serial link, both ends.
// Assumes: Both ends run on a 125 MHz ref_clk_i.
// Notes:   Host register offsets are byte addresses on the host's plain port.
package fault_diag_pkg;

	// =====================================================================
	// Diagnostic word layout
	localparam int DIAG_BITS = 8;
	localparam int CHANNELS  = 4;
	localparam int OT_LSB    = 0;  // Over-temperature flags, channels A to D.
	localparam int OL_LSB    = 4;  // Open-load flags, channels A to D.

	// =====================================================================
	// Timing
	localparam int CLK_PERIOD_NS = 8;
	localparam int INT_PULSE_NS  = 3000;
	localparam int SCK_HALF_NS   = 250;
	localparam int LEAD_LAG_NS   = 250;
	localparam logic [8:0] INT_PULSE_CYCLES =
		9'((INT_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam logic [7:0] SCK_HALF_CYCLES =
		8'((SCK_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam logic [7:0] LEAD_LAG_CYCLES =
		8'((LEAD_LAG_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

	// =====================================================================
	// Device input synchroniser layout and its reset value
	localparam int S_CS    = 0;
	localparam int S_SCK   = 1;
	localparam int S_SI    = 2;
	localparam int S_RST   = 3;
	localparam int S_POR   = 4;
	localparam int S_IN    = 5;
	localparam int S_OT    = 9;
	localparam int S_OL    = 13;
	localparam int S_WIDTH = 17;
	localparam logic [16:0] SYNC_RESET = 17'h0_0019;

	// =====================================================================
	// Host registers
	localparam logic [7:0] CTRL_ADDR     = 8'h00;
	localparam logic [7:0] STATUS_ADDR   = 8'h04;
	localparam logic [7:0] TXDATA_ADDR   = 8'h08;
	localparam logic [7:0] RXDATA_ADDR   = 8'h0C;
	localparam logic [7:0] IRQ_STAT_ADDR = 8'h10;
	localparam logic [7:0] IRQ_MASK_ADDR = 8'h14;
	localparam int CTRL_START_BIT = 0;
	localparam int CTRL_RESET_BIT = 1;
	localparam int CTRL_LEN_LSB   = 4;
	localparam int STAT_BUSY_BIT  = 0;
	localparam int IRQ_DONE_BIT   = 0;
	localparam int IRQ_FAULT_BIT  = 1;
	localparam logic [1:0] LEN_RESET = 2'h0;

endpackage

// File: rtl/fault_diag_if.sv
// Purpose: Four-wire diagnostic link plus reset and interrupt lines.
// Assumes: The serial output and the interrupt line are pulled high when undriven.
// Notes:   Line levels are resolved here from the drivers' enables.
interface fault_diag_if;

	logic cs_n;
	logic sck;
	logic si;
	logic rst_n;
	logic so;
	logic so_oe;
	logic int_oe;
	logic so_line;
	logic int_line;

	// =====================================================================
	// Wire resolution: an undriven line reads as its pull-up.
	assign so_line  = so_oe ? so : 1'b1;
	assign int_line = int_oe ? 1'b0 : 1'b1;

	modport device (
		input  cs_n,
		input  sck,
		input  si,
		input  rst_n,
		output so,
		output so_oe,
		output int_oe
	);

	modport host (
		output cs_n,
		output sck,
		output si,
		output rst_n,
		input  so_line,
		input  int_line
	);

endinterface

// File: rtl/fault_diag_device.sv
// Purpose: Device end: fault flags, diagnostic shift register, one-shot, gates.
// Assumes: Every link pin and channel input is asynchronous to ref_clk_i.
// Notes:   All pins pass a two-stage synchroniser, so reactions lag by cycles.
//
// What this block and its host must do
// R1: Chained devices share select and clock.
// R2: Select falling loads flags into shift register.
// R3: Host keeps clock low when select falls.
// R4: Output floats while deselected, low until clocking.
// R5: Host keeps clock low when select rises.
// R6: Host clocks whole frame without a break.
// R7: Reset clears flags, keeps shift register.
// R8: Reset forces every output switch off.
// R9: Host clears register by selecting after reset.
// R10: Low supply keeps every output switch off.
// R11: Host resets after any supply dip.
// R12: MSB first, out on rise, in on fall.
// R13: Bits 0-3 over-temp, bits 4-7 open-load.
// R14: New flag fires one-shot, retriggers ignored.
// R15: Over-temp latches off until input rises.
// R16: Synchronise select, clock, reset; detect edges.
module fault_diag_device (
	input  wire logic        ref_clk_i,
	input  wire logic        reset_i,
	fault_diag_if.device     link,
	input  wire logic [3:0]  chan_in_i,
	input  wire logic [3:0]  ot_detect_i,
	input  wire logic [3:0]  ol_detect_i,
	input  wire logic        supply_ok_i,
	output logic      [3:0]  gate_on_o,
	output logic      [7:0]  diag_flags_o
);

	// =====================================================================
	// State
	// Everything the device remembers lives in one record, so that one
	// process computes its next value and one process registers it.
	typedef struct packed {
		logic [16:0] sync1;
		logic [16:0] sync2;
		logic [16:0] prev;
		logic [7:0]  shift;
		logic        so;
		logic        so_oe;
		logic        so_hold;
		logic [3:0]  overtemp_flag;
		logic [3:0]  open_load_flag;
		logic [3:0]  off_latch;
		logic [8:0]  int_cnt;
		logic [3:0]  gate;
	} state_t;

	state_t st_reg;
	state_t st_next;

	// Decoded views of the synchronised pins. All of them are given a value
	// on every path of the next-state process, so none of them holds state.
	logic [16:0] cur;
	logic [16:0] rise;
	logic [16:0] fall;
	logic [3:0]  in_rise;
	logic [3:0]  in_fall;
	logic [3:0]  ot_det;
	logic [3:0]  ol_det;
	logic [7:0]  flags_now;
	logic [7:0]  flags_new;
	logic        link_reset;
	logic        enable_out;

	// =====================================================================
	// Next-state logic
	// One combinational process computes the whole next record.
	always_comb
	begin
		st_next = st_reg;

		// Every pin goes through two flops; edges are found after the second.
		// Only the second stage feeds logic, so a metastable first stage never
		// reaches a decision. The price is about three cycles of lag on each pin,
		// which is why the host's half periods must be well above four cycles.
		st_next.sync1 = {ol_detect_i, ot_detect_i, chan_in_i, supply_ok_i,
			link.rst_n, link.si, link.sck, link.cs_n}; // [R16]
		st_next.sync2 = st_reg.sync1;
		st_next.prev  = st_reg.sync2;
		cur  = st_reg.sync2;
		rise = cur & ~st_reg.prev; // [R16]
		fall = ~cur & st_reg.prev; // [R16]

		// Reset and supply are levels, so only their present state counts.
		// A low supply and a link reset both withdraw the output enable.
		in_rise    = rise[fault_diag_pkg::S_IN +: 4];
		in_fall    = fall[fault_diag_pkg::S_IN +: 4];
		ot_det     = cur[fault_diag_pkg::S_OT +: 4];
		ol_det     = cur[fault_diag_pkg::S_OL +: 4];
		link_reset = ~cur[fault_diag_pkg::S_RST];
		enable_out = ~link_reset & cur[fault_diag_pkg::S_POR];

		// A detection in the same cycle as the clearing edge keeps the flag.
		// Over-temperature clears on a rising channel input, open-load on a
		// falling one, since open-load is only sensed while the channel is off.
		// The flags are levels held here; the sensing itself is outside.
		st_next.overtemp_flag  = (st_reg.overtemp_flag & ~in_rise) | ot_det;
		st_next.open_load_flag = (st_reg.open_load_flag & ~in_fall) | ol_det;

		// An over-temperature fault holds its channel off until the input rises.
		// If the fault is still sensed, the latch sets again at once, so a hot
		// channel cannot be switched back on by toggling its input.
		st_next.off_latch = (st_reg.off_latch & ~in_rise) | ot_det; // [R15]

		// Reset wipes the flags and latches but leaves the shift register.
		// Clearing the latches too lets every channel restart cleanly once the
		// reset lifts; the register only picks up the cleared flags at a select.
		if (link_reset)
		begin
			st_next.overtemp_flag  = '0; // [R7]
			st_next.open_load_flag = '0; // [R7]
			st_next.off_latch      = '0;
		end

		// Gate drive follows the channel input unless something forces it off.
		// The supply pin is synchronised like the rest, so the gates drop a few
		// cycles after the supply sags; users must allow for that lag.
		st_next.gate = cur[fault_diag_pkg::S_IN +: 4] & ~st_next.off_latch
			& {4{enable_out}}; // [R8] [R10]

		// The one-shot fires only on a newly set flag and ignores retriggers.
		// Flags that appear during the pulse are still stored and can be read
		// serially; they only fail to raise a second pulse.
		flags_now = {st_reg.open_load_flag, st_reg.overtemp_flag};
		flags_new = {st_next.open_load_flag, st_next.overtemp_flag} & ~flags_now;
		if (st_reg.int_cnt != 9'h000)
		begin
			st_next.int_cnt = st_reg.int_cnt - 9'h001; // [R14]
		end
		else if (|flags_new)
		begin
			st_next.int_cnt = fault_diag_pkg::INT_PULSE_CYCLES; // [R14]
		end

		// Shift path; chained devices simply see the same select and clock.
		// Select high wins over any clock edge, so stray clocking between frames
		// is ignored. From select fall until the first rising clock edge the
		// output is held low, so a chained neighbour never sees a floating bit.
		if (cur[fault_diag_pkg::S_CS])
		begin
			st_next.so_oe   = 1'b0; // [R4]
			st_next.so_hold = 1'b0;
		end
		else if (fall[fault_diag_pkg::S_CS])
		begin
			st_next.shift   = flags_now; // [R2] [R13]
			st_next.so      = 1'b0; // [R4]
			st_next.so_oe   = 1'b1; // [R4]
			st_next.so_hold = 1'b1;
		end
		else if (rise[fault_diag_pkg::S_SCK])
		begin
			st_next.so      = st_reg.shift[fault_diag_pkg::DIAG_BITS - 1]; // [R12]
			st_next.so_hold = 1'b0; // [R4]
		end
		else if (fall[fault_diag_pkg::S_SCK])
		begin
			// Capturing at the far edge lets a chained neighbour's bit settle.
			st_next.shift = {st_reg.shift[6:0], cur[fault_diag_pkg::S_SI]}; // [R12] [R1]
		end
	end

	// =====================================================================
	// State register
	// The synchroniser stages reset to the idle levels of their pins: select
	// and link reset high, supply good. Resetting them to zero would make a
	// false rising select edge and a brief link reset the moment reset lifts.
	always_ff @(posedge ref_clk_i)
	begin
		if (reset_i)
		begin
			st_reg <= '{
				sync1:          fault_diag_pkg::SYNC_RESET,
				sync2:          fault_diag_pkg::SYNC_RESET,
				prev:           fault_diag_pkg::SYNC_RESET,
				shift:          8'h00,
				so:             1'b0,
				so_oe:          1'b0,
				so_hold:        1'b0,
				overtemp_flag:  4'h0,
				open_load_flag: 4'h0,
				off_latch:      4'h0,
				int_cnt:        9'h000,
				gate:           4'h0
			};
		end
		else
		begin
			st_reg <= st_next;
		end
	end

	// =====================================================================
	// Outputs
	// Every output comes straight from the state record; none is decoded
	// from the pins, so the link sees no glitch from the synchronisers.
	// The hold flag forces a low level from select fall to the first rising
	// clock edge, whatever the data flop holds.
	assign link.so      = st_reg.so & ~st_reg.so_hold; // [R4]
	assign link.so_oe   = st_reg.so_oe;
	assign link.int_oe  = (st_reg.int_cnt != 9'h000); // Open drain, pulls low.
	assign gate_on_o    = st_reg.gate;
	assign diag_flags_o = {st_reg.open_load_flag, st_reg.overtemp_flag};

endmodule

// File: rtl/fault_diag_host.sv
// Purpose: Host end: frames diagnostic transfers for a chain of one to four devices.
// Assumes: Software writes the transmit word before starting a frame.
// Notes:   Frame length is 8 bits per chained device; data is right-justified.
//
// The implementer's own choices: the register addresses and the plain strobed port.
module fault_diag_host (
	input  wire logic        ref_clk_i,
	input  wire logic        reset_i,
	fault_diag_if.host       link,
	input  wire logic [7:0]  addr_i,
	input  wire logic [31:0] wdata_i,
	input  wire logic        wr_i,
	input  wire logic        rd_i,
	output logic      [31:0] rdata_o,
	output logic             irq_o
);

	typedef enum logic [2:0] {IDLE, LEAD, HIGH, LOW, LAG, GAP} phase_t;

	// =====================================================================
	// State
	typedef struct packed {
		phase_t      phase;
		logic [7:0]  cnt;
		logic [5:0]  bits;
		logic [31:0] tx;
		logic [31:0] rx;
		logic        cs_n;
		logic        sck;
		logic        si;
		logic        rst_n;
		logic [1:0]  len;
		logic [31:0] txdata;
		logic [31:0] rxdata;
		logic [1:0]  irq_stat;
		logic [1:0]  irq_mask;
		logic [31:0] rdata;
		logic [1:0]  so_sync;
		logic [2:0]  int_sync;
	} state_t;

	state_t st_reg;
	state_t st_next;

	logic       start;
	logic [1:0] new_len;
	logic [1:0] irq_set;
	logic [1:0] irq_clr;

	// =====================================================================
	// Next-state logic
	always_comb
	begin
		st_next          = st_reg;
		st_next.so_sync  = {st_reg.so_sync[0], link.so_line};
		st_next.int_sync = {st_reg.int_sync[1:0], link.int_line};
		irq_set          = 2'h0;
		irq_clr          = 2'h0;
		new_len          = wdata_i[fault_diag_pkg::CTRL_LEN_LSB +: 2];
		start            = 1'b0;

		// Register writes; the reset line level can change at any time.
		if (wr_i)
		begin
			unique case (addr_i)
				fault_diag_pkg::CTRL_ADDR:
				begin
					st_next.rst_n = ~wdata_i[fault_diag_pkg::CTRL_RESET_BIT];
					start = wdata_i[fault_diag_pkg::CTRL_START_BIT];
				end
				fault_diag_pkg::TXDATA_ADDR:   st_next.txdata = wdata_i;
				fault_diag_pkg::IRQ_STAT_ADDR: irq_clr = wdata_i[1:0];
				fault_diag_pkg::IRQ_MASK_ADDR: st_next.irq_mask = wdata_i[1:0];
				default:                       st_next.irq_mask = st_reg.irq_mask;
			endcase
		end

		// Framing: clock idles low around select edges, bits run unbroken.
		st_next.cnt = st_reg.cnt - 8'h01;
		unique case (st_reg.phase)
			IDLE:
			begin
				st_next.cnt = st_reg.cnt;
				if (start)
				begin
					st_next.len   = new_len;
					// A fresh frame must not carry bits of the last one above its length.
					st_next.rx    = 32'h0000_0000;
					st_next.bits  = {new_len, 3'b000} + 6'h08;
					st_next.tx    = st_reg.txdata << {~new_len, 3'b000};
					st_next.si    = st_next.tx[31];
					st_next.cs_n  = 1'b0; // [R3] [R1]
					st_next.cnt   = fault_diag_pkg::LEAD_LAG_CYCLES - 8'h01;
					st_next.phase = LEAD;
				end
			end
			LEAD:
			begin
				if (st_reg.cnt == 8'h00)
				begin
					st_next.sck   = 1'b1;
					st_next.cnt   = fault_diag_pkg::SCK_HALF_CYCLES - 8'h01;
					st_next.phase = HIGH;
				end
			end
			HIGH:
			begin
				if (st_reg.cnt == 8'h00)
				begin
					st_next.rx    = {st_reg.rx[30:0], st_reg.so_sync[1]};
					st_next.tx    = {st_reg.tx[30:0], 1'b0};
					st_next.bits  = st_reg.bits - 6'h01;
					st_next.sck   = 1'b0;
					st_next.cnt   = fault_diag_pkg::SCK_HALF_CYCLES - 8'h01;
					st_next.phase = LOW;
				end
			end
			LOW:
			begin
				if (st_reg.cnt == 8'h00)
				begin
					st_next.cnt = fault_diag_pkg::SCK_HALF_CYCLES - 8'h01;
					if (st_reg.bits == 6'h00)
					begin
						st_next.cnt   = fault_diag_pkg::LEAD_LAG_CYCLES - 8'h01;
						st_next.phase = LAG; // [R5]
					end
					else
					begin
						st_next.si    = st_reg.tx[31];
						st_next.sck   = 1'b1; // [R6]
						st_next.phase = HIGH;
					end
				end
			end
			LAG:
			begin
				if (st_reg.cnt == 8'h00)
				begin
					st_next.cs_n   = 1'b1; // [R5]
					st_next.rxdata = st_reg.rx;
					irq_set[fault_diag_pkg::IRQ_DONE_BIT] = 1'b1;
					st_next.cnt   = fault_diag_pkg::LEAD_LAG_CYCLES - 8'h01;
					st_next.phase = GAP;
				end
			end
			GAP:
			begin
				if (st_reg.cnt == 8'h00)
				begin
					st_next.phase = IDLE;
				end
			end
		endcase

		// Sticky events; a set in the clearing cycle survives.
		irq_set[fault_diag_pkg::IRQ_FAULT_BIT] = st_reg.int_sync[2] & ~st_reg.int_sync[1];
		st_next.irq_stat = (st_reg.irq_stat & ~irq_clr) | irq_set;

		// Read data stand only in the cycle after the read strobe.
		st_next.rdata = 32'h0000_0000;
		if (rd_i)
		begin
			unique case (addr_i)
				fault_diag_pkg::CTRL_ADDR:
					st_next.rdata = {26'h000_0000, st_reg.len, 2'b00, ~st_reg.rst_n, 1'b0};
				fault_diag_pkg::STATUS_ADDR:
					st_next.rdata = {31'h0000_0000, st_reg.phase != IDLE};
				fault_diag_pkg::TXDATA_ADDR:   st_next.rdata = st_reg.txdata;
				fault_diag_pkg::RXDATA_ADDR:   st_next.rdata = st_reg.rxdata;
				fault_diag_pkg::IRQ_STAT_ADDR: st_next.rdata = {30'h0000_0000, st_reg.irq_stat};
				fault_diag_pkg::IRQ_MASK_ADDR: st_next.rdata = {30'h0000_0000, st_reg.irq_mask};
				default:                       st_next.rdata = 32'h0000_0000;
			endcase
		end
	end

	// =====================================================================
	// State register
	always_ff @(posedge ref_clk_i)
	begin
		if (reset_i)
		begin
			st_reg          <= '0;
			st_reg.phase    <= IDLE;
			st_reg.cs_n     <= 1'b1;
			st_reg.rst_n    <= 1'b1;
			st_reg.len      <= fault_diag_pkg::LEN_RESET;
			st_reg.so_sync  <= 2'b11;
			st_reg.int_sync <= 3'b111;
		end
		else
		begin
			st_reg <= st_next;
		end
	end

	// =====================================================================
	// Outputs
	assign link.cs_n  = st_reg.cs_n;
	assign link.sck   = st_reg.sck;
	assign link.si    = st_reg.si;
	assign link.rst_n = st_reg.rst_n;
	assign rdata_o    = st_reg.rdata;
	assign irq_o      = |(st_reg.irq_stat & st_reg.irq_mask);

endmodule

// File: verif/fault_diag_sva.sv
// Purpose: Assertions on the link that joins the host end to the device end.
// Assumes: One host and one device share the interface signals seen here.
// Notes:   Device reactions lag its input synchroniser by a few cycles.
module fault_diag_sva (
	input  wire logic ref_clk_i,
	input  wire logic reset_i,
	input  wire logic cs_n,
	input  wire logic sck,
	input  wire logic rst_n,
	input  wire logic so,
	input  wire logic so_oe,
	input  wire logic int_oe
);
	timeunit 1ns;
	timeprecision 1ps;

	// =====================================================================
	// Helper logic
	logic [8:0] int_cnt_reg;
	logic [8:0] int_cnt_next;

	// Counts the cycles of a pulse so that its exact width can be judged.
	always_comb int_cnt_next = int_oe ? int_cnt_reg + 9'h001 : 9'h000;
	always_ff @(posedge ref_clk_i) int_cnt_reg <= reset_i ? 9'h000 : int_cnt_next;

	default clocking cb @(posedge ref_clk_i); endclocking
	default disable iff (reset_i);

	// =====================================================================
	// Properties
	property p_so_float;
		cs_n [*6] |-> !so_oe;
	endproperty
	property p_so_release;
		$rose(cs_n) |-> ##[1:6] !so_oe;
	endproperty
	property p_so_lead;
		$fell(cs_n) |-> ##6 (so_oe && !so) [*8];
	endproperty
	property p_sck_low_sel;
		$fell(cs_n) |-> !sck [*8];
	endproperty
	property p_sck_low_desel;
		$rose(cs_n) |-> !sck && !$past(sck);
	endproperty
	property p_frame_whole;
		$fell(sck) |-> (##[1:40] $rose(sck)) or (##[1:72] $rose(cs_n));
	endproperty
	property p_so_on_rise;
		so_oe && $past(so_oe) && (so != $past(so)) |-> sck;
	endproperty
	property p_int_width;
		$fell(int_oe) |-> int_cnt_reg == fault_diag_pkg::INT_PULSE_CYCLES;
	endproperty
	property p_int_max;
		int_oe |-> int_cnt_reg < fault_diag_pkg::INT_PULSE_CYCLES;
	endproperty

	a_so_float: assert property (p_so_float) else $error("output driven while idle");
	a_so_release: assert property (p_so_release) else $error("output held");
	a_so_lead: assert property (p_so_lead) else $error("output not low");
	a_sck_low_sel: assert property (p_sck_low_sel) else $error("clock high at select");
	a_sck_low_desel: assert property (p_sck_low_desel) else $error("clock high at end");
	a_frame_whole: assert property (p_frame_whole) else $error("frame broken");
	a_so_on_rise: assert property (p_so_on_rise) else $error("output moved off rise");
	a_int_width: assert property (p_int_width) else $error("pulse width");
	a_int_max: assert property (p_int_max) else $error("pulse too long");

	c_frame: cover property ($fell(cs_n));
	c_int: cover property ($rose(int_oe));
	c_rst: cover property ($fell(rst_n));
endmodule

// File: verif/fault_diag_serial_link_tb.sv
// Purpose: Self-checking bench for both ends of the diagnostic link.
// Assumes: One device on the link; host registers reached over the plain port.
// Notes:   Pin reactions lag the synchroniser, so checks settle a few cycles.
module fault_diag_serial_link_tb;
	timeunit 1ns;
	timeprecision 1ps;

	// =====================================================================
	// Signals and instances
	logic        ref_clk_i = 1'b0;
	logic        reset_i = 1'b1;
	logic [7:0]  addr = 8'h00;
	logic [31:0] wdata = 32'h0000_0000;
	logic        wr = 1'b0;
	logic        rd = 1'b0;
	logic [31:0] rdata;
	logic        irq;
	logic [3:0]  chan_in = 4'h0;
	logic [3:0]  ot_det = 4'h0;
	logic [3:0]  ol_det = 4'h0;
	logic        supply_ok = 1'b1;
	logic [3:0]  gate_on;
	logic [7:0]  diag_flags;
	logic [31:0] d;
	int          n_errors = 0;
	int          check_count = 0;

	fault_diag_if link_if ();

	fault_diag_host fault_diag_host_inst (
		.ref_clk_i (ref_clk_i),
		.reset_i   (reset_i),
		.link      (link_if),
		.addr_i    (addr),
		.wdata_i   (wdata),
		.wr_i      (wr),
		.rd_i      (rd),
		.rdata_o   (rdata),
		.irq_o     (irq)
	);

	fault_diag_device fault_diag_device_inst (
		.ref_clk_i    (ref_clk_i),
		.reset_i      (reset_i),
		.link         (link_if),
		.chan_in_i    (chan_in),
		.ot_detect_i  (ot_det),
		.ol_detect_i  (ol_det),
		.supply_ok_i  (supply_ok),
		.gate_on_o    (gate_on),
		.diag_flags_o (diag_flags)
	);

	fault_diag_sva fault_diag_sva_inst (
		.ref_clk_i (ref_clk_i),
		.reset_i   (reset_i),
		.cs_n      (link_if.cs_n),
		.sck       (link_if.sck),
		.rst_n     (link_if.rst_n),
		.so        (link_if.so),
		.so_oe     (link_if.so_oe),
		.int_oe    (link_if.int_oe)
	);

	// Clock of 8 ns.
	always #4 ref_clk_i = ~ref_clk_i;

	// =====================================================================
	// Shared tasks
	task automatic finish_test;
		$display("errors %0d checks %0d", n_errors, check_count);
		if (n_errors == 0 && check_count > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp)
		begin
			n_errors++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// Outputs are sampled on the falling edge, well clear of any update.
	task automatic settle(input int n);
		repeat (n) @(posedge ref_clk_i);
		@(negedge ref_clk_i);
	endtask

	task automatic wr_reg(input logic [7:0] a, input logic [31:0] v);
		@(posedge ref_clk_i);
		wr <= 1'b1;
		addr <= a;
		wdata <= v;
		@(posedge ref_clk_i);
		wr <= 1'b0;
	endtask

	task automatic rd_reg(input logic [7:0] a, output logic [31:0] v);
		@(posedge ref_clk_i);
		rd <= 1'b1;
		addr <= a;
		@(posedge ref_clk_i);
		rd <= 1'b0;
		@(negedge ref_clk_i);
		v = rdata;
	endtask

	// Starts one frame, polls busy under a bound and checks the word read back.
	task automatic run_frame(input logic [31:0] ctrl, input logic [31:0] exp);
		int i;
		wr_reg(fault_diag_pkg::CTRL_ADDR, ctrl | 32'h0000_0001);
		d = 32'h0000_0001;
		for (i = 0; i < 1000 && d[0] !== 1'b0; i++)
			rd_reg(fault_diag_pkg::STATUS_ADDR, d);
		if (d[0] !== 1'b0)
		begin
			n_errors++;
			$display("wrong value at %0t: frame did not finish", $time);
			finish_test();
		end
		else
		begin
			rd_reg(fault_diag_pkg::RXDATA_ADDR, d);
			chk(d, exp);
		end
	endtask

	// =====================================================================
	// Scenarios
	// A fault pulls the line, masking gates the host output, a second fault is ignored.
	task automatic t_irq;
		@(posedge ref_clk_i);
		ol_det <= 4'h1;
		settle(8);
		chk(32'(diag_flags), 32'h0000_0010);
		rd_reg(fault_diag_pkg::IRQ_STAT_ADDR, d);
		chk(d, 32'h0000_0002);
		chk(32'(irq), 32'h0000_0000);
		wr_reg(fault_diag_pkg::IRQ_MASK_ADDR, 32'h0000_0002);
		settle(2);
		chk(32'(irq), 32'h0000_0001);
		wr_reg(fault_diag_pkg::IRQ_STAT_ADDR, 32'h0000_0002);
		settle(2);
		chk(32'(irq), 32'h0000_0000);
		@(posedge ref_clk_i);
		ot_det <= 4'h1;
		settle(8);
		rd_reg(fault_diag_pkg::IRQ_STAT_ADDR, d);
		chk(d, 32'h0000_0000);
		settle(400);
		rd_reg(fault_diag_pkg::IRQ_STAT_ADDR, d);
		chk(d, 32'h0000_0000);
		rd_reg(8'h20, d);
		chk(d, 32'h0000_0000);
	endtask

	// Mixed flags come back in their bit places, first received bit highest.
	task automatic t_frame;
		@(posedge ref_clk_i);
		ot_det <= 4'h6;
		ol_det <= 4'h8;
		settle(8);
		run_frame(32'h0000_0000, 32'h0000_0097);
		// A two-device length loops the sent byte back through the shift path.
		wr_reg(fault_diag_pkg::TXDATA_ADDR, 32'h0000_A55A);
		run_frame(32'h0000_0010, 32'h0000_97A5);
		rd_reg(fault_diag_pkg::CTRL_ADDR, d);
		chk(d, 32'h0000_0010);
		rd_reg(fault_diag_pkg::IRQ_STAT_ADDR, d);
		chk(d & 32'h0000_0001, 32'h0000_0001);
		wr_reg(fault_diag_pkg::IRQ_STAT_ADDR, 32'h0000_0003);
	endtask

	// Latched channels stay off until their input rises; link reset clears all.
	task automatic t_gates;
		@(posedge ref_clk_i);
		chan_in <= 4'hF;
		settle(8);
		chk(32'(gate_on), 32'h0000_0009);
		chk(32'(diag_flags), 32'h0000_0096);
		@(posedge ref_clk_i);
		ot_det <= 4'h0;
		ol_det <= 4'h0;
		settle(8);
		chk(32'(gate_on), 32'h0000_0009);
		wr_reg(fault_diag_pkg::CTRL_ADDR, 32'h0000_0002);
		settle(8);
		chk(32'(diag_flags), 32'h0000_0000);
		chk(32'(gate_on), 32'h0000_0000);
		run_frame(32'h0000_0002, 32'h0000_0000);
		wr_reg(fault_diag_pkg::CTRL_ADDR, 32'h0000_0000);
		settle(8);
		chk(32'(gate_on), 32'h0000_000F);
	endtask

	// A low supply forces every switch off whatever the inputs say.
	task automatic t_supply;
		@(posedge ref_clk_i);
		ol_det <= 4'h2;
		supply_ok <= 1'b0;
		settle(8);
		chk(32'(gate_on), 32'h0000_0000);
		@(posedge ref_clk_i);
		ol_det <= 4'h0;
		supply_ok <= 1'b1;
		settle(8);
		chk(32'(gate_on), 32'h0000_000F);
		chk(32'(diag_flags), 32'h0000_0020);
		// After the dip the host resets and reloads before trusting the register.
		wr_reg(fault_diag_pkg::CTRL_ADDR, 32'h0000_0002);
		settle(8);
		run_frame(32'h0000_0002, 32'h0000_0000);
		wr_reg(fault_diag_pkg::CTRL_ADDR, 32'h0000_0000);
		settle(8);
		chk(32'(diag_flags), 32'h0000_0000);
	endtask

	// =====================================================================
	// Main sequence
	initial
	begin
		repeat (20) @(posedge ref_clk_i);
		reset_i <= 1'b0;
		settle(4);
		t_irq();
		t_frame();
		t_gates();
		t_supply();
		finish_test();
	end
endmodule
